// >>> hw/hcc_pkg.sv
// hcc_pkg: constants for the clock capability register bank
// assumes a 32-bit apb slave at a fixed base; offsets are byte addresses
package hcc_pkg;
	// register byte offsets
	localparam logic [7:0] CAP_LOW_OFS     = 8'h00; // clock capabilities, read only
	localparam logic [7:0] BASE_MHZ_OFS    = 8'h04; // true base clock in whole mhz
	localparam logic [7:0] BASE_FRAC_OFS   = 8'h08; // nonzero if base has a fraction
	localparam logic [7:0] TMO_CFG_OFS     = 8'h0c; // timeout clock value and unit
	localparam logic [7:0] VERSION_OFS     = 8'h10; // controller version select
	// field positions in the capability word
	localparam int BASE_LSB = 8;
	localparam int TMO_UNIT_BIT = 7;
	localparam int RSVD_BIT = 6;
	// version codes
	localparam logic [1:0] VER_100 = 2'h0;
	localparam logic [1:0] VER_200 = 2'h1;
	localparam logic [1:0] VER_300 = 2'h2;
	// reset values of the strap registers
	localparam logic [7:0] BASE_MHZ_RST  = 8'h32;
	localparam logic       BASE_FRAC_RST = 1'h0;
	localparam logic [5:0] TMO_FREQ_RST  = 6'h01;
	localparam logic       TMO_UNIT_RST  = 1'h1;
	localparam logic [1:0] VERSION_RST   = 2'h2;
	// encoding limits
	localparam logic [8:0] BASE_MAX6 = 9'h03f;
	localparam logic [8:0] BASE_MAX8 = 9'h0ff;
	localparam logic [8:0] BASE_MIN  = 9'h00a;
	// bus answer
	localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;
endpackage : hcc_pkg

// >>> hw/hcc_encode.sv
// hcc_encode: builds the capability word from the hardware-init settings
// assumes inputs are stable registered values; purely combinational
`timescale 1ns/100ps
`default_nettype none
module hcc_encode (
	input  wire logic [7:0]  i_base_mhz,
	input  wire logic        i_base_frac,
	input  wire logic [1:0]  i_version,
	input  wire logic [5:0]  i_tmo_freq,
	input  wire logic        i_tmo_unit,
	output logic      [31:0] o_cap
);
	logic [8:0] rounded;
	logic       wide;
	logic [8:0] limit;
	logic [7:0] base_field;

	// round any fractional base up so the divider never overclocks the card
	assign rounded = {1'h0, i_base_mhz} + {8'h00, i_base_frac};
	assign wide = (i_version == hcc_pkg::VER_300);
	assign limit = wide ? hcc_pkg::BASE_MAX8 : hcc_pkg::BASE_MAX6;
	// zero and out-of-range values report "use another method"
	assign base_field = (i_base_mhz == 8'h00 || rounded > limit || rounded < hcc_pkg::BASE_MIN)
		? 8'h00 : rounded[7:0];
	// reserved bit 6 and upper half read zero
	assign o_cap = {16'h0000, base_field, i_tmo_unit, 1'h0, i_tmo_freq};
endmodule : hcc_encode
`default_nettype wire

// >>> hw/hcc_regs.sv
// hcc_regs: clock capability register bank behind an apb slave
// assumes apb3 master on i_sys_clk; hardware-init values written before use
// Function
// - base card clock reported in bits 15:8
// - versions 1 and 2 use six-bit base
// - six-bit base in mhz, 10 to 63
// - version 3 uses eight bits, up to 255
// - zero base means obtain frequency elsewhere
// - fractional base rounds up to next mhz
// - bit 7 selects timeout unit khz/mhz
// - bits 5:0 timeout frequency 1 to 63
// - zero timeout field means obtain elsewhere
`timescale 1ns/100ps
`default_nettype none
module hcc_regs (
	input  wire logic        i_sys_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic        i_hardware_initialized,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr
);
	logic [7:0]  base_mhz;
	logic        base_frac;
	logic [5:0]  tmo_freq;
	logic        tmo_unit;
	logic [1:0]  version;
	logic [31:0] cap;
	logic        setup;
	logic        wr_ok;
	logic        hit_cap;
	logic        hit_base;
	logic        hit_frac;
	logic        hit_tmo;
	logic        hit_ver;
	logic        mapped;
	logic [31:0] next_prdata;
	logic        next_pslverr;

	// capability word is pure function of the init settings
	hcc_encode u_enc (
		.i_base_mhz  (base_mhz),
		.i_base_frac (base_frac),
		.i_version   (version),
		.i_tmo_freq  (tmo_freq),
		.i_tmo_unit  (tmo_unit),
		.o_cap       (cap)
	);

	// address decode; registers answer in the cycle after setup
	assign setup    = i_psel && !i_penable;
	assign hit_cap  = (i_paddr == hcc_pkg::CAP_LOW_OFS);
	assign hit_base = (i_paddr == hcc_pkg::BASE_MHZ_OFS);
	assign hit_frac = (i_paddr == hcc_pkg::BASE_FRAC_OFS);
	assign hit_tmo  = (i_paddr == hcc_pkg::TMO_CFG_OFS);
	assign hit_ver  = (i_paddr == hcc_pkg::VERSION_OFS);
	assign mapped   = hit_cap || hit_base || hit_frac || hit_tmo || hit_ver;
	// settings lock once init is declared done, so capability stays fixed
	assign wr_ok    = i_psel && i_penable && o_pready && i_pwrite && !i_hardware_initialized;

	assign next_prdata = !setup || i_pwrite ? 32'h0000_0000 :
		hit_cap  ? cap :
		hit_base ? {24'h000000, base_mhz} :
		hit_frac ? {31'h00000000, base_frac} :
		hit_tmo  ? {24'h000000, tmo_unit, 1'b0, tmo_freq} :
		hit_ver  ? {30'h00000000, version} : hcc_pkg::UNMAPPED_RDATA;
	// writes to the capability word are refused with an error, as are holes
	assign next_pslverr = setup && (!mapped || (i_pwrite && (hit_cap || i_hardware_initialized)));

	// bus answer registers
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pready  <= 1'h0;
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'h0;
		end else begin
			o_pready  <= setup;
			o_prdata  <= next_prdata;
			o_pslverr <= next_pslverr;
		end
	end

	// hardware-init settings, writable only before init completes
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			base_mhz  <= hcc_pkg::BASE_MHZ_RST;
			base_frac <= hcc_pkg::BASE_FRAC_RST;
			tmo_freq  <= hcc_pkg::TMO_FREQ_RST;
			tmo_unit  <= hcc_pkg::TMO_UNIT_RST;
			version   <= hcc_pkg::VERSION_RST;
		end else if (wr_ok) begin
			if (hit_base) base_mhz <= i_pwdata[7:0];
			if (hit_frac) base_frac <= i_pwdata[0];
			if (hit_tmo) begin
				tmo_freq <= i_pwdata[5:0];
				tmo_unit <= i_pwdata[7];
			end
			if (hit_ver) version <= i_pwdata[1:0];
		end
	end

	// assertions
	property p_rsvd_zero;
		@(posedge i_sys_clk) disable iff (!i_nrst) cap[hcc_pkg::RSVD_BIT] == 1'b0 && cap[31:16] == 16'h0000;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");
	property p_six_bit;
		@(posedge i_sys_clk) disable iff (!i_nrst) version != hcc_pkg::VER_300 |-> cap[15:14] == 2'b00;
	endproperty
	a_six_bit: assert property (p_six_bit) else $error("six-bit base has upper bits");
	property p_range;
		@(posedge i_sys_clk) disable iff (!i_nrst) cap[15:8] == 8'h00 || cap[15:8] >= 8'h0a;
	endproperty
	a_range: assert property (p_range) else $error("base below 10 mhz");
	property p_round;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			(cap[15:8] != 8'h00 && base_frac) |-> cap[15:8] == base_mhz + 8'h01;
	endproperty
	a_round: assert property (p_round) else $error("fraction not rounded up");
	property p_exact;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			(cap[15:8] != 8'h00 && !base_frac) |-> cap[15:8] == base_mhz;
	endproperty
	a_exact: assert property (p_exact) else $error("base field mismatch");
	property p_zero_base;
		@(posedge i_sys_clk) disable iff (!i_nrst) base_mhz == 8'h00 |-> cap[15:8] == 8'h00;
	endproperty
	a_zero_base: assert property (p_zero_base) else $error("zero base not reported");
	property p_wide;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			(version == hcc_pkg::VER_300 && base_mhz >= 8'h40 && !base_frac) |-> cap[15:8] == base_mhz;
	endproperty
	a_wide: assert property (p_wide) else $error("eight-bit base lost");
	property p_tmo;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			cap[5:0] == tmo_freq && cap[hcc_pkg::TMO_UNIT_BIT] == tmo_unit;
	endproperty
	a_tmo: assert property (p_tmo) else $error("timeout fields wrong");
	property p_locked;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			i_hardware_initialized && $stable(i_hardware_initialized) |=> $stable(cap);
	endproperty
	a_locked: assert property (p_locked) else $error("capability changed after init");
	property p_answer;
		@(posedge i_sys_clk) disable iff (!i_nrst) (i_psel && !i_penable) |=> o_pready;
	endproperty
	a_answer: assert property (p_answer) else $error("no ready after setup");

	// the answer lasts one cycle; a legal master never asks twice back to back
	property p_ready_pulse;
		@(posedge i_sys_clk) disable iff (!i_nrst) o_pready |=> !o_pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past one cycle");

	// writes return zero data so stale reads cannot leak through
	property p_write_rdata;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			(o_pready && i_pwrite) |-> o_prdata == 32'h0000_0000;
	endproperty
	a_write_rdata: assert property (p_write_rdata) else $error("write returned data");

	// the capability word is read only
	property p_cap_werr;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			(setup && i_pwrite && hit_cap) |=> o_pslverr;
	endproperty
	a_cap_werr: assert property (p_cap_werr) else $error("capability write not refused");

	// once init is declared done every write bounces
	property p_lock_werr;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			(setup && i_pwrite && i_hardware_initialized) |=> o_pslverr;
	endproperty
	a_lock_werr: assert property (p_lock_werr) else $error("locked write not refused");

	// settings hold still while init is high, whatever the bus does
	property p_frozen;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			i_hardware_initialized |=> $stable(base_mhz) && $stable(base_frac)
				&& $stable(version) && $stable(tmo_freq) && $stable(tmo_unit);
	endproperty
	a_frozen: assert property (p_frozen) else $error("settings changed after init");

	// a read of the capability word returns the word of the setup cycle
	property p_cap_read;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			(setup && !i_pwrite && hit_cap) |=> o_prdata == $past(cap);
	endproperty
	a_cap_read: assert property (p_cap_read) else $error("capability read wrong");

	// reads of mapped registers never raise an error
	property p_read_ok;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			(setup && !i_pwrite && mapped) |=> !o_pslverr;
	endproperty
	a_read_ok: assert property (p_read_ok) else $error("mapped read refused");

	// holes answer with an error and the fixed fill value
	property p_unmapped;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			(setup && !mapped) |=> o_pslverr && o_prdata == hcc_pkg::UNMAPPED_RDATA;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

	// a base write before init lands in the low byte only
	property p_base_store;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			(wr_ok && hit_base) |=> {24'h000000, base_mhz} == ($past(i_pwdata) & 32'h0000_00ff);
	endproperty
	a_base_store: assert property (p_base_store) else $error("base setting not stored");

	// the timeout setting skips the reserved bit, so bit 6 of the data is dropped
	property p_tmo_store;
		@(posedge i_sys_clk) disable iff (!i_nrst)
			(wr_ok && hit_tmo) |=>
				{24'h000000, tmo_unit, 1'h0, tmo_freq} == ($past(i_pwdata) & 32'h0000_00bf);
	endproperty
	a_tmo_store: assert property (p_tmo_store) else $error("timeout setting not stored");

	// scenarios worth seeing
	c_read_cap: cover property (@(posedge i_sys_clk) o_pready && hit_cap && !i_pwrite);
	c_round: cover property (@(posedge i_sys_clk) base_frac && cap[15:8] != 8'h00);
	c_wide: cover property (@(posedge i_sys_clk) cap[15:14] != 2'b00);
	c_err: cover property (@(posedge i_sys_clk) o_pslverr);
	c_lock_bounce: cover property (@(posedge i_sys_clk) o_pslverr && i_hardware_initialized && i_pwrite);
endmodule : hcc_regs
`default_nettype wire

// >>> bench/host_clock_capability_fields_tb.sv
// host_clock_capability_fields_tb: self-checking bench for the capability bank
// assumes hcc_regs answers one access cycle after setup, at byte offsets
`timescale 1ns/100ps
`default_nettype none
module host_clock_capability_fields_tb;
	logic        clk  = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        pen  = 1'b0;
	logic        pw   = 1'b0;
	logic        init = 1'b0;
	logic [7:0]  pa   = 8'h00;
	logic [31:0] wd   = 32'h0;
	logic [31:0] prd, rd;
	logic        rdy, slv, err;
	int          bad_count = 0;
	int          cmp_count = 0;
	logic [7:0]  tbl [6] = '{8'h00, 8'h09, 8'h0a, 8'h3f, 8'h40, 8'hff};

	always #50 clk = ~clk;

	hcc_regs hcc_regs_i (.i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pw), .i_paddr(pa), .i_pwdata(wd), .i_hardware_initialized(init),
		.o_prdata(prd), .o_pready(rdy), .o_pslverr(slv));

	// expected word; fraction rounds up, out-of-range codes read as unknown (zero)
	function automatic logic [31:0] exp_cap(logic [7:0] b, logic f, logic [1:0] v,
		logic [5:0] t, logic u);
		logic [8:0] r;
		r = {1'b0, b} + {8'h00, f};
		if (b == 8'h00 || r < 9'h00a || r > (v == 2'h2 ? 9'h0ff : 9'h03f)) r = 9'h000;
		return {16'h0000, r[7:0], u, 1'b0, t};
	endfunction : exp_cap

	task automatic results;
		$display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
			bad_count++;
		end
	endtask : chk

	// one apb transfer; request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1; pen <= 1'b0; pw <= w; pa <= a; wd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			results();
		end
		rd = prd;
		err = slv;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	// load settings, lock them, then check the word and that writes bounce
	task automatic run(logic [7:0] b, logic f, logic [1:0] v, logic [5:0] t, logic u);
		@(posedge clk) init <= 1'b0;
		apb(1'b1, 8'h04, {24'h0, b});
		chk({31'h0, err}, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 8'h08, {31'h0, f});
		apb(1'b1, 8'h0c, {24'h0, u, 1'b0, t});
		apb(1'b1, 8'h10, {30'h0, v});
		@(posedge clk) init <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, exp_cap(b, f, v, t, u));
		chk({31'h0, err}, 32'h0);
		apb(1'b1, 8'h00, 32'hffff_ffff);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, 8'h04, {24'h0, ~b});
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, exp_cap(b, f, v, t, u));
	endtask : run

	initial begin
		void'($urandom(78));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		// defaults: 50 mhz base, 1 mhz timeout clock
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_3281);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		// boundary bases against every version
		for (int i = 0; i < 18; i++)
			run(tbl[i % 6], i[0], 2'(i / 6), 6'(i), i[1]);
		// random settings, timeout field may be zero
		repeat (20)
			run(8'($urandom), 1'($urandom), 2'($urandom_range(2)), 6'($urandom), 1'($urandom));
		results();
	end
endmodule : host_clock_capability_fields_tb
`default_nettype wire
